// ### src/irs_pkg.sv
// Constants shared by the interrupt and reset status block.
// Assumes a 100 MHz device clock and 8-bit register accesses from the internal serial link.
package irs_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] IMR_OFFSET = 8'h09;
  localparam logic [7:0] IFR_OFFSET = 8'h0A;
  localparam logic [7:0] RSR_OFFSET = 8'h0D;

  // ==========================================================================
  // Flag and enable bit positions, shared by the flag and mask registers except the mask-only BIT_OT_INHIBIT
  // ==========================================================================
  localparam int unsigned SRC_COUNT      = 7;
  localparam int unsigned BIT_STAGE      = 0;
  localparam int unsigned BIT_OVERVOLT   = 1;
  localparam int unsigned BIT_UNDERVOLT  = 2;
  localparam int unsigned BIT_OVERTEMP   = 3;
  localparam int unsigned BIT_BUS_WAKE   = 4;
  localparam int unsigned BIT_HALL       = 5;
  localparam int unsigned BIT_WAKE_INPUT = 6;
  localparam int unsigned BIT_OT_INHIBIT = 7;

  // ==========================================================================
  // Reset status bit positions
  // ==========================================================================
  localparam int unsigned BIT_POWER_ON   = 0;
  localparam int unsigned BIT_PIN_RST    = 1;
  localparam int unsigned BIT_WDOG_RST   = 2;
  localparam int unsigned BIT_OT_RST     = 3;
  localparam int unsigned BIT_LOW_RST    = 4;
  localparam int unsigned BIT_BUS_WF     = 5;
  localparam int unsigned BIT_INPUT_WF   = 6;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] IMR_RESET = 8'h00;
  localparam logic [7:0] IFR_RESET = 8'h00;
  localparam logic [7:0] RSR_RESET = 8'h01;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS      = 10000;
  localparam int unsigned RST_STRETCH_NS     = 1250000;
  localparam int unsigned RST_STRETCH_CYCLES = (RST_STRETCH_NS * 1000) / CLK_PERIOD_PS;

endpackage : irs_pkg

// ### src/irs_stretch.sv
// Reset stretch counter: holds its output for a set number of cycles after the event ends.
// Assumes the event input is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module irs_stretch #(
  parameter int unsigned STRETCH_CYCLES = irs_pkg::RST_STRETCH_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic ce,
  // Event and stretched output
  input  wire logic event_in,
  output logic      hold
);

  localparam int unsigned CW = $clog2(STRETCH_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(STRETCH_CYCLES);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          hold_reg;
  logic          hold_next;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    if (event_in)
    begin
      cnt_next = LOAD;
    end
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - CW'(1);
    end
    else
    begin
      cnt_next = cnt_reg;
    end
    hold_next = event_in || (cnt_next != '0);
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      // Power-on reset loads the full stretch so the pin stays low after release.
      cnt_reg  <= LOAD;
      hold_reg <= 1'b1;
    end
    else if (ce)
    begin
      cnt_reg  <= cnt_next;
      hold_reg <= hold_next;
    end
  end

  assign hold = hold_reg;

endmodule : irs_stretch

`default_nettype wire

// ### src/irs_top.sv
// Interrupt flags, interrupt mask, reset sources, reset pin stretching and reset status.
// Assumes synchronous inputs from the analog detectors and single-cycle register strobes.
`timescale 1ns/1ps
`default_nettype none

module irs_top #(
  parameter int unsigned STRETCH_CYCLES = irs_pkg::RST_STRETCH_CYCLES
) (
  // Clock, power-on reset, clock enable
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // Register port from the serial link
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Detector conditions and events
  input  wire logic       overvolt_cond,
  input  wire logic       undervolt_cond,
  input  wire logic       overtemp_cond,
  input  wire logic       stage_fault_any,
  input  wire logic       bus_wake_evt,
  input  wire logic       hall_edge_evt,
  input  wire logic       wake_input_evt,
  input  wire logic       wdog_reset_req,
  input  wire logic       vdd_low,
  input  wire logic       sleep_wake_bus,
  input  wire logic       sleep_wake_input,
  // Open-drain reset pin
  input  wire logic       rst_pin_in,
  output logic            rst_pin_out,
  output logic            rst_pin_oe_n,
  // Interrupt request
  output logic            irq_n
);

  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       req_prev_reg;
  logic       req_prev_next;
  logic       req_now;
  logic       irq_n_reg;
  logic       irq_n_next;
  logic       oe_n_reg;
  logic       oe_n_next;
  logic       pin_out_reg;
  logic       ot_trip;
  logic       wdog_trip;
  logic       int_evt;
  logic       ext_pin_rst;
  logic       soft_rst;
  logic       stretch_hold;
  logic [6:0] src_set;
  logic [6:0] src_cond;
  logic [7:0] flag_w1c;
  logic [7:0] status_w1c;

  // ==========================================================================
  // Register decode
  // ==========================================================================
  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] offset,
                                  input logic wr);
    wr_hit = wr && (addr == offset);
  endfunction : wr_hit

  // ==========================================================================
  // Reset sources
  // ==========================================================================
  assign ot_trip     = overtemp_cond && !mask_reg[irs_pkg::BIT_OT_INHIBIT];
  assign wdog_trip   = wdog_reset_req;
  assign int_evt     = ot_trip || wdog_trip || vdd_low;
  // The pin reads low while we drive it, so only a low seen while released is external.
  assign ext_pin_rst = !rst_pin_in && oe_n_reg;
  assign soft_rst    = int_evt || ext_pin_rst;

  irs_stretch #(
    .STRETCH_CYCLES (STRETCH_CYCLES)
  ) irs_stretch_i (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .ce       (ce),
    .event_in (int_evt),
    .hold     (stretch_hold)
  );

  // ==========================================================================
  // Flag, mask and status next values
  // ==========================================================================
  always_comb
  begin
    src_set = '0;
    src_cond = '0;
    src_set[irs_pkg::BIT_OVERVOLT]   = overvolt_cond;
    src_set[irs_pkg::BIT_UNDERVOLT]  = undervolt_cond;
    src_set[irs_pkg::BIT_OVERTEMP]   = overtemp_cond;
    src_set[irs_pkg::BIT_BUS_WAKE]   = bus_wake_evt;
    src_set[irs_pkg::BIT_HALL]       = hall_edge_evt;
    src_set[irs_pkg::BIT_WAKE_INPUT] = wake_input_evt;
    src_cond[irs_pkg::BIT_OVERVOLT]  = overvolt_cond;
    src_cond[irs_pkg::BIT_UNDERVOLT] = undervolt_cond;
    src_cond[irs_pkg::BIT_OVERTEMP]  = overtemp_cond;
    flag_w1c = wr_hit(reg_addr, irs_pkg::IFR_OFFSET, reg_wr) ? reg_wdata : 8'h00;
    status_w1c = wr_hit(reg_addr, irs_pkg::RSR_OFFSET, reg_wr) ? reg_wdata : 8'h00;

    mask_next = mask_reg;
    if (wr_hit(reg_addr, irs_pkg::IMR_OFFSET, reg_wr))
    begin
      mask_next = reg_wdata;
    end

    flag_next = 8'h00;
    for (int i = 1; i < irs_pkg::SRC_COUNT; i++)
    begin
      // A set in the same cycle as a write of one wins over the clear.
      flag_next[i] = src_set[i] || (flag_reg[i] && !(flag_w1c[i] && !src_cond[i]));
    end
    flag_next[irs_pkg::BIT_STAGE] = stage_fault_any;

    status_next = status_reg & ~status_w1c;
    status_next[irs_pkg::BIT_OT_RST]   = status_next[irs_pkg::BIT_OT_RST] || ot_trip;
    status_next[irs_pkg::BIT_WDOG_RST] = status_next[irs_pkg::BIT_WDOG_RST] || wdog_trip;
    status_next[irs_pkg::BIT_LOW_RST]  = status_next[irs_pkg::BIT_LOW_RST] || vdd_low;
    status_next[irs_pkg::BIT_PIN_RST]  = status_next[irs_pkg::BIT_PIN_RST] || ext_pin_rst;
    status_next[irs_pkg::BIT_BUS_WF]   = status_next[irs_pkg::BIT_BUS_WF] || sleep_wake_bus;
    status_next[irs_pkg::BIT_INPUT_WF] = status_next[irs_pkg::BIT_INPUT_WF]
                                         || sleep_wake_input;
    status_next[7] = 1'b0;

    if (soft_rst)
    begin
      mask_next = irs_pkg::IMR_RESET;
      flag_next = irs_pkg::IFR_RESET;
    end
  end

  // ==========================================================================
  // Interrupt, pin and read data next values
  // ==========================================================================
  always_comb
  begin
    req_now    = |(flag_reg[irs_pkg::SRC_COUNT-1:0] & mask_reg[irs_pkg::SRC_COUNT-1:0]);
    irq_n_next = !(req_now && !req_prev_reg);
    oe_n_next  = !stretch_hold;
    req_prev_next = req_now;
    if (soft_rst)
    begin
      // A reset in progress forgets the old request so no stale pulse follows it.
      req_prev_next = 1'b0;
      irq_n_next    = 1'b1;
    end
    rdata_next = rdata_reg;
    if (reg_rd)
    begin
      case (reg_addr)
        irs_pkg::IMR_OFFSET: rdata_next = mask_reg;
        irs_pkg::IFR_OFFSET: rdata_next = flag_reg;
        irs_pkg::RSR_OFFSET: rdata_next = status_reg;
        default:             rdata_next = irs_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      mask_reg     <= irs_pkg::IMR_RESET;
      flag_reg     <= irs_pkg::IFR_RESET;
      status_reg   <= irs_pkg::RSR_RESET;
      rdata_reg    <= irs_pkg::RDATA_UNMAPPED;
      req_prev_reg <= 1'b0;
      irq_n_reg    <= 1'b1;
      oe_n_reg     <= 1'b0;
      pin_out_reg  <= 1'b0;
    end
    else if (ce)
    begin
      mask_reg     <= mask_next;
      flag_reg     <= flag_next;
      status_reg   <= status_next;
      rdata_reg    <= rdata_next;
      req_prev_reg <= req_prev_next;
      irq_n_reg    <= irq_n_next;
      oe_n_reg     <= oe_n_next;
      pin_out_reg  <= 1'b0;
    end
  end

  assign reg_rdata    = rdata_reg;
  assign irq_n        = irq_n_reg;
  assign rst_pin_oe_n = oe_n_reg;
  assign rst_pin_out  = pin_out_reg;

endmodule : irs_top

`default_nettype wire

// ### verif/irs_sva.sv
// Checker for the interrupt and reset status block, bound to its top module.
// Assumes ce is high whenever a watched event, access or interrupt pulse is in flight.
`timescale 1ns/1ps
`default_nettype none

module irs_sva #(
  parameter int unsigned STRETCH_CYCLES = irs_pkg::RST_STRETCH_CYCLES
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Detectors and outputs
  input wire logic       overvolt_cond,
  input wire logic       wdog_reset_req,
  input wire logic       vdd_low,
  input wire logic       rst_pin_oe_n,
  input wire logic       rst_pin_out,
  input wire logic       irq_n
);
  // ==========================================================================
  // Length of the current low drive on the reset pin
  // ==========================================================================
  int unsigned low_cnt_reg;
  int unsigned low_cnt_next;

  always_comb
  begin
    low_cnt_next = rst_pin_oe_n ? 0 : low_cnt_reg + 1;
  end

  always_ff @(posedge ref_clk)
  begin
    low_cnt_reg <= nrst ? low_cnt_next : 0;
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_pin_out_low: assert property (!rst_pin_oe_n |-> !rst_pin_out)
    else $error("reset pin driven with a high level");
  chk_irq_one_cycle: assert property (!irq_n |=> irq_n)
    else $error("irq_n low longer than one cycle");
  chk_irq_soft_quiet: assert property (vdd_low [*2] |-> irq_n)
    else $error("irq pulse during low voltage reset");
  chk_oe_on_vdd: assert property ($rose(vdd_low) |-> ##2 !rst_pin_oe_n)
    else $error("reset pin not driven after low voltage");
  chk_oe_on_wdog: assert property ($rose(wdog_reset_req) |-> ##2 !rst_pin_oe_n)
    else $error("reset pin not driven after watchdog request");
  chk_stretch_len: assert property ($rose(rst_pin_oe_n) |-> low_cnt_reg >= STRETCH_CYCLES)
    else $error("reset pin released before stretch time");
  chk_oe_after_por: assert property ($rose(nrst) |-> !rst_pin_oe_n [*4])
    else $error("reset pin released too early after power-on");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h09, 8'h0A, 8'h0D})
    |=> reg_rdata == irs_pkg::RDATA_UNMAPPED)
    else $error("unmapped read returned nonzero");
  chk_ov_w1c_kept: assert property (reg_wr && reg_addr == irs_pkg::IFR_OFFSET && reg_wdata[1]
    && overvolt_cond ##2 reg_rd && reg_addr == irs_pkg::IFR_OFFSET |=> reg_rdata[1])
    else $error("overvoltage flag cleared while condition present");
endmodule : irs_sva

bind irs_top irs_sva #(.STRETCH_CYCLES(STRETCH_CYCLES)) irs_sva_i (
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .overvolt_cond(overvolt_cond),
  .wdog_reset_req(wdog_reset_req), .vdd_low(vdd_low), .rst_pin_oe_n(rst_pin_oe_n),
  .irq_n(irq_n), .rst_pin_out(rst_pin_out)
);

`default_nettype wire

// ### verif/irs_mcu_model.sv
// Processor-side model: register strobes over the serial link and the reset pin pull-up.
// Assumes its tasks are called from the ref_clk domain.
`timescale 1ns/1ps
`default_nettype none

module irs_mcu_model (
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output var  logic [7:0] reg_addr  = 8'h00,
  output var  logic [7:0] reg_wdata = 8'h00,
  output var  logic       reg_wr    = 1'b0,
  output var  logic       reg_rd    = 1'b0,
  // Reset pin
  input  wire logic       rst_pin_out,
  input  wire logic       rst_pin_oe_n,
  output wire logic       rst_pin_in
);
  logic ext_low = 1'b0;

  // The pin has a pull-up; it is low when either party pulls it down.
  assign rst_pin_in = !(ext_low || (!rst_pin_oe_n && !rst_pin_out));

  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : access

  task automatic pin_pulse();
    @(posedge ref_clk);
    ext_low <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ext_low <= 1'b0;
  endtask : pin_pulse
endmodule : irs_mcu_model

`default_nettype wire

// ### verif/irs_top_bench.sv
// Self-checking bench for the interrupt and reset status block.
// Assumes the checker is bound to irs_top and the processor model drives the register port.
`timescale 1ns/1ps
`default_nettype none

module irs_top_bench;
  localparam logic [7:0] INTERRUPT_ENABLE_MASK = irs_pkg::IMR_OFFSET;
  localparam logic [7:0] INTERRUPT_EVENT_FLAGS = irs_pkg::IFR_OFFSET;
  localparam logic [7:0] RESET_CAUSE_AND_WAKE_STATUS = irs_pkg::RSR_OFFSET;
  logic       ref_clk = 1'b0;
  logic       nrst    = 1'b0;
  logic       ce      = 1'b1;
  logic [6:0] ev      = '0;
  logic       wdog    = 1'b0;
  logic       vlow    = 1'b0;
  logic [1:0] swk     = '0;
  logic [7:0] rsr_bit [4] = '{8'h10, 8'h04, 8'h08, 8'h02};
  logic [7:0] v;
  wire logic [7:0] addr, wdata, rdata;
  wire logic  wr_strobe, rd, pin_in, pin_out, oe_n, irq_n;
  logic [7:0] exp_q [$];
  int mismatches = 0;
  int checked    = 0;
  int irq_cnt    = 0;
  bit pend       = 0;

  irs_top #(.STRETCH_CYCLES(8)) irs_top_i (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr_strobe), .reg_rd(rd), .reg_rdata(rdata), .stage_fault_any(ev[0]),
    .overvolt_cond(ev[1]), .undervolt_cond(ev[2]), .overtemp_cond(ev[3]),
    .bus_wake_evt(ev[4]), .hall_edge_evt(ev[5]), .wake_input_evt(ev[6]),
    .wdog_reset_req(wdog), .vdd_low(vlow), .sleep_wake_bus(swk[0]), .sleep_wake_input(swk[1]),
    .rst_pin_in(pin_in), .rst_pin_out(pin_out), .rst_pin_oe_n(oe_n), .irq_n(irq_n));
  irs_mcu_model irs_mcu_model_i (
    .ref_clk(ref_clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_strobe), .reg_rd(rd),
    .rst_pin_out(pin_out), .rst_pin_oe_n(oe_n), .rst_pin_in(pin_in));

  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    irs_mcu_model_i.access(1'b0, a, 8'h00);
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    irs_mcu_model_i.access(1'b1, a, d);
  endtask : wr

  task automatic wait_oe();
    for (int n = 0; n < 100 && oe_n !== 1'b1; n++)
      @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
  endtask : wait_oe

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Read data appears one edge after the read is taken.
  always @(posedge ref_clk)
  begin
    #1;
    if (irq_n === 1'b0)
      irq_cnt++;
    if (pend)
      cmp("reg_rdata", exp_q.pop_front(), rdata);
    pend = rd;
  end

  initial
  begin
    #100us;
    mismatches++;
    $display("[FAIL] run_time expected done seen timeout");
    give_verdict();
  end

  initial
  begin
    v = 8'($urandom(32'h1BA6E1AB));
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_oe();
    rd_chk(INTERRUPT_ENABLE_MASK, 8'h00);
    rd_chk(INTERRUPT_EVENT_FLAGS, 8'h00);
    rd_chk(RESET_CAUSE_AND_WAKE_STATUS, 8'h01);
    rd_chk(8'h0B, 8'h00);
    wr(RESET_CAUSE_AND_WAKE_STATUS, 8'hFF);
    rd_chk(RESET_CAUSE_AND_WAKE_STATUS, 8'h00);
    v = 8'($urandom);
    wr(INTERRUPT_ENABLE_MASK, v);
    rd_chk(INTERRUPT_ENABLE_MASK, v);
    $display("test reset_values done");
    @(posedge ref_clk);
    ev[1:0] <= 2'b11;
    wr(INTERRUPT_EVENT_FLAGS, 8'h03);
    ev[1] <= 1'b0;
    rd_chk(INTERRUPT_EVENT_FLAGS, 8'h03);
    ev[0] <= 1'b0;
    rd_chk(INTERRUPT_EVENT_FLAGS, 8'h02);
    wr(INTERRUPT_EVENT_FLAGS, 8'h02);
    rd_chk(INTERRUPT_EVENT_FLAGS, 8'h00);
    $display("test flag_clear done");
    for (int i = 0; i < 7; i++)
      for (int en = 0; en < 2; en++)
      begin
        wr(INTERRUPT_ENABLE_MASK, (8'(en) << i) | (i == 3 ? 8'h80 : 8'h00));
        irq_cnt = 0;
        @(posedge ref_clk);
        ev[i] <= 1'b1;
        @(posedge ref_clk);
        ev[i] <= 1'b0;
        repeat (5) @(posedge ref_clk);
        cmp("irq_pulses", 8'(en), 8'(irq_cnt));
        rd_chk(INTERRUPT_EVENT_FLAGS, i == 0 ? 8'h00 : 8'h01 << i);
        wr(INTERRUPT_EVENT_FLAGS, 8'hFF);
        rd_chk(INTERRUPT_EVENT_FLAGS, 8'h00);
      end
    wr(INTERRUPT_ENABLE_MASK, 8'h20);
    irq_cnt = 0;
    @(posedge ref_clk);
    ce    <= 1'b0;
    ev[5] <= 1'b1;
    @(posedge ref_clk);
    ev[5] <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ce    <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cmp("irq_frozen", 8'h00, 8'(irq_cnt));
    rd_chk(INTERRUPT_EVENT_FLAGS, 8'h00);
    rd_chk(RESET_CAUSE_AND_WAKE_STATUS, 8'h00);
    $display("test interrupt_sources done");
    @(posedge ref_clk);
    swk <= 2'b11;
    @(posedge ref_clk);
    swk <= 2'b00;
    rd_chk(RESET_CAUSE_AND_WAKE_STATUS, 8'h60);
    wr(RESET_CAUSE_AND_WAKE_STATUS, 8'h20);
    rd_chk(RESET_CAUSE_AND_WAKE_STATUS, 8'h40);
    nrst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_oe();
    rd_chk(RESET_CAUSE_AND_WAKE_STATUS, 8'h01);
    rd_chk(INTERRUPT_ENABLE_MASK, 8'h00);
    wr(RESET_CAUSE_AND_WAKE_STATUS, 8'h01);
    $display("test wake_flags done");
    for (int k = 0; k < 4; k++)
    begin
      wr(INTERRUPT_ENABLE_MASK, 8'h55);
      @(posedge ref_clk);
      vlow  <= (k == 0);
      wdog  <= (k == 1);
      ev[3] <= (k == 2);
      if (k == 3)
        irs_mcu_model_i.pin_pulse();
      else
        repeat (3) @(posedge ref_clk);
      vlow  <= 1'b0;
      wdog  <= 1'b0;
      ev[3] <= 1'b0;
      repeat (3) @(posedge ref_clk);
      wait_oe();
      rd_chk(INTERRUPT_ENABLE_MASK, 8'h00);
      rd_chk(RESET_CAUSE_AND_WAKE_STATUS, rsr_bit[k]);
      wr(RESET_CAUSE_AND_WAKE_STATUS, rsr_bit[k]);
      rd_chk(RESET_CAUSE_AND_WAKE_STATUS, 8'h00);
      wr(INTERRUPT_EVENT_FLAGS, 8'hFF);
    end
    $display("test reset_sources done");
    repeat (3) @(posedge ref_clk);
    give_verdict();
  end
endmodule : irs_top_bench

`default_nettype wire
